// file: bench/input_press_decoder_events_tb_top.sv
// Purpose: Self-checking bench for the input press decoder
// Assumes: Millisecond tick shortened to 10 cycles
// Notes:   Event pulses are matched in order against a queue of notes
`timescale 1ns/1ps
module input_press_decoder_events_tb_top;
  localparam int CPM = 10;
  logic        sys_clk, nrst, regWr, regRd, rOff, rMild, rHigh;
  logic        bForty, bTwenty, bCrit;
  logic [3:0]  regAddr, pins;
  logic [31:0] regWdata, regRdata, d;
  logic [9:0]  battVolt;
  logic [1:0]  lines;
  logic [4:0]  q[$];
  int          fail_count = 0;
  int          n_compared = 0;
  int          ms;
  int          hi;

  ipd_top #(.CYCLES_PER_MS(CPM)) uut (
    .sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .inputEventLine(lines), .battVolt(battVolt),
    .outputPatternSignal(pins), .remoteOffAlertTrigger(rOff),
    .remoteMildAlertTrigger(rMild), .remoteHighAlertTrigger(rHigh),
    .batteryFortyEvent(bForty), .batteryTwentyEvent(bTwenty),
    .batteryCritical(bCrit));
  ipd_button_model #(.ACT(2'b01)) btn (.sys_clk(sys_clk), .line(lines));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Checking
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic final_report();
    if (fail_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // Pulses last one cycle, so look mid-cycle
  always @(negedge sys_clk)
    if ({rOff, rMild, rHigh, bForty, bTwenty} !== 5'h00)
      check({rOff, rMild, rHigh, bForty, bTwenty},
            q.size() ? q.pop_front() : 5'h00);

  task automatic drain(input int bound);
    repeat (bound) if (q.size() != 0) @(posedge sys_clk);
    if (q.size() != 0)
    begin
      fail_count++;
      final_report();
    end
  endtask : drain

  // ****************************************
  // Register port
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask : rd

  task automatic settle_pin(input logic exp);
    repeat (5) @(posedge sys_clk);
    check(pins[0], exp);
  endtask : settle_pin

  initial
  begin
    nrst = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWdata = 32'h0;
    battVolt = 10'h3e8;
    void'($urandom(32'hd85b));
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(ipd_pkg::ADDR_CTRL, d);
    check(d, ipd_pkg::CTRL_RST);
    rd(ipd_pkg::ADDR_THRESH, d);
    check(d, ipd_pkg::THRESH_RST);
    wr(4'hd, 32'hffff_ffff);
    rd(4'hd, d);
    check(d, 32'h0);
    // t1 70 ms, t2 120 ms; line1 active low, connected
    wr(ipd_pkg::ADDR_THRESH, 32'h0078_0046);
    wr(ipd_pkg::ADDR_CTRL, 32'h0000_0005);
    wr(ipd_pkg::ADDR_ALERT, 32'h1b12_1314);
    wr(ipd_pkg::ADDR_MUTE, 32'h0000_0001);
    wr(ipd_pkg::ADDR_PORT0, 32'h0000_0015);
    for (int k = 0; k < 3; k++)
    begin
      ms = (k == 0) ? 55 + $urandom % 8 :
           (k == 1) ? 80 + $urandom % 25 : 130 + $urandom % 20;
      q.push_back(5'h10 >> k);
      btn.press(0, ms * CPM);
      drain(300);
    end
    settle_pin(1'b1);
    btn.press(1, 55 * CPM);
    settle_pin(1'b0);
    q.push_back(5'h10);
    btn.press(0, 55 * CPM);
    drain(300);
    wr(ipd_pkg::ADDR_CTRL, 32'h0000_0001);
    btn.press(1, 55 * CPM);
    settle_pin(1'b1);
    // PWM port on line0 activation, 3-cycle half period
    wr(ipd_pkg::ADDR_PWM, 32'h0000_0002);
    wr(ipd_pkg::ADDR_PORT0 + 4'h3, 32'h0000_0015);
    q.push_back(5'h10);
    btn.press(0, 55 * CPM);
    drain(300);
    // Any full period holds exactly half its cycles high
    hi = 0;
    repeat (6) @(negedge sys_clk) hi += pins[3];
    check(hi, 3);
    wr(ipd_pkg::ADDR_BATT_A, 32'h0258_0320);
    wr(ipd_pkg::ADDR_BATT_B, 32'h00c8_0190);
    q.push_back(5'h02);
    battVolt <= 10'h12c;
    drain(20);
    check(bCrit, 1'b0);
    q.push_back(5'h01);
    battVolt <= 10'h096;
    drain(20);
    rd(ipd_pkg::ADDR_STATUS, d);
    check({bCrit, d[13:10]}, 5'h1c);
    wr(ipd_pkg::ADDR_CTRL, 32'h0000_0009);
    repeat (3) @(posedge sys_clk);
    check(pins, 4'h0);
    final_report();
  end
endmodule : input_press_decoder_events_tb_top

// file: bench/ipd_button_model.sv
// Purpose: Push-button model for the two input lines
// Assumes: Lines are sampled on the rising edge of sys_clk
// Notes:   A released line sits at the inverse of its active level
`timescale 1ns/1ps
module ipd_button_model #(
  parameter logic [1:0] ACT = 2'b01
) (
  input  wire logic sys_clk,
  output logic [1:0] line
);
  initial line = ~ACT;

  task automatic press(input int idx, input int cyc);
    @(posedge sys_clk);
    line[idx] <= ACT[idx];
    repeat (cyc) @(posedge sys_clk);
    line[idx] <= ~ACT[idx];
  endtask : press
endmodule : ipd_button_model

// file: core/ipd_line_decoder.sv
// Purpose: Classifies the pulses of one input line into press events
// Assumes: Line is synchronous to sys_clk; msTick is one pulse per ms
// Notes:   All event outputs are one-cycle pulses from flip-flops
`timescale 1ns/1ps
module ipd_line_decoder (
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  input  wire logic                   lineIn,
  input  wire logic                   activeHigh,
  input  wire logic                   msTick,
  input  wire logic [15:0]            t1Ms,
  input  wire logic [15:0]            t2Ms,
  output ipd_pkg::ipd_press_type      events,
  output logic                        isActive
);

  ipd_pkg::ipd_dec_state_type stateReg;
  ipd_pkg::ipd_dec_state_type stateNext;
  ipd_pkg::ipd_press_type     evReg;
  ipd_pkg::ipd_press_type     evNext;
  logic [15:0]                holdMsReg;
  logic [15:0]                holdMsNext;

  wire lineActive = (lineIn == activeHigh);
  wire [15:0] holdInc = (holdMsReg == 16'hffff) ? holdMsReg
                                                : holdMsReg + 16'h0001;
  wire counting  = (stateReg == ipd_pkg::HELD) && lineActive && msTick;
  wire reachT1   = counting && (holdInc == t1Ms);
  wire reachT2   = counting && (holdInc == t2Ms);
  wire released  = (stateReg == ipd_pkg::HELD) && !lineActive;
  // Shorter pulses are glitches and give no press
  wire validHold = (holdMsReg >= ipd_pkg::MIN_HOLD_MS);

  always_comb
  begin
    stateNext = stateReg;
    unique case (stateReg)
      ipd_pkg::IDLE:
        if (lineActive) stateNext = ipd_pkg::HELD;
      ipd_pkg::HELD:
        if (!lineActive) stateNext = ipd_pkg::IDLE;
        else if (reachT2) stateNext = ipd_pkg::LONG_DONE;
      ipd_pkg::LONG_DONE:
        if (!lineActive) stateNext = ipd_pkg::IDLE;
    endcase
  end

  assign holdMsNext = (stateReg != ipd_pkg::HELD || released) ? 16'h0000
                    : (counting ? holdInc : holdMsReg);

  assign evNext.act     = (stateReg == ipd_pkg::IDLE) && lineActive;
  assign evNext.shortP  = released && validHold && holdMsReg < t1Ms;
  assign evNext.mediumP = released && validHold && holdMsReg >= t1Ms
                          && holdMsReg < t2Ms;
  assign evNext.longP   = reachT2;
  assign evNext.fb1     = reachT1;
  assign evNext.fb2     = reachT2;

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      stateReg  <= ipd_pkg::IDLE;
      holdMsReg <= 16'h0000;
      evReg     <= '0;
    end
    else
    begin
      stateReg  <= stateNext;
      holdMsReg <= holdMsNext;
      evReg     <= evNext;
    end
  end

  assign events   = evReg;
  assign isActive = lineActive;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  act_on_rise_a: assert property (
    $rose(lineActive) && stateReg == ipd_pkg::IDLE |=> evReg.act)
    else $error("activation missing on line rise");
  one_class_a: assert property (
    $onehot0({evReg.shortP, evReg.mediumP, evReg.longP}))
    else $error("more than one press class");
  short_class_a: assert property (
    evReg.shortP |-> $past(holdMsReg) < t1Ms && !lineActive
                     && $past(holdMsReg) >= ipd_pkg::MIN_HOLD_MS)
    else $error("short press with wrong hold time");
  medium_class_a: assert property (
    evReg.mediumP |-> $past(holdMsReg) >= t1Ms && $past(holdMsReg) < t2Ms)
    else $error("medium press with wrong hold time");
  long_at_t2_a: assert property (
    evReg.longP |-> holdMsReg == t2Ms && stateReg == ipd_pkg::LONG_DONE)
    else $error("long press not at second threshold");
  feedback_t1_a: assert property (
    evReg.fb1 |-> holdMsReg == t1Ms)
    else $error("first feedback not at first threshold");

  long_press_c: cover property (evReg.longP);
  medium_press_c: cover property (evReg.mediumP);

endmodule : ipd_line_decoder

// file: core/ipd_pkg.sv
// Purpose: Shared constants and types for the input press decoder
// Assumes: 100 MHz system clock
// Notes:   Register index is the word address on the plain port
package ipd_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          NS_PER_MS     = 1000000;
  localparam int          CYCLES_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
  localparam logic [15:0] MIN_HOLD_MS   = 16'h0032;
  localparam int          BATT_LSB_UV   = 3520;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_THRESH = 4'h1;
  localparam logic [3:0] ADDR_BATT_A = 4'h2;
  localparam logic [3:0] ADDR_BATT_B = 4'h3;
  localparam logic [3:0] ADDR_ALERT  = 4'h4;
  localparam logic [3:0] ADDR_MUTE   = 4'h5;
  localparam logic [3:0] ADDR_PORT0  = 4'h6;
  localparam logic [3:0] ADDR_PWM    = 4'ha;
  localparam logic [3:0] ADDR_STATUS = 4'hb;

  localparam int CTRL_CONN  = 2;
  localparam int CTRL_SLEEP = 3;
  localparam int ALERT_OFF  = 0;
  localparam int ALERT_MILD = 8;
  localparam int ALERT_HIGH = 16;
  localparam int ALERT_MUTE = 24;

  localparam logic [31:0] CTRL_RST   = 32'h0000_0003;
  localparam logic [31:0] THRESH_RST = 32'h07d0_01f4;

  // ****************************************
  // Battery level codes, smaller is fuller
  // ****************************************
  localparam logic [2:0] LEVEL_100 = 3'h0;
  localparam logic [2:0] LEVEL_80  = 3'h1;
  localparam logic [2:0] LEVEL_60  = 3'h2;
  localparam logic [2:0] LEVEL_40  = 3'h3;
  localparam logic [2:0] LEVEL_20  = 3'h4;

  typedef struct packed {
    logic act;
    logic shortP;
    logic mediumP;
    logic longP;
    logic fb1;
    logic fb2;
  } ipd_press_type;

  typedef struct packed {
    logic [3:0] count;
    logic [7:0] offMs;
    logic [7:0] onMs;
    logic       rsvd;
    logic       repeatOn;
    logic       invert;
    logic       enable;
    logic [3:0] evSel;
  } ipd_port_cfg_type;

  typedef enum logic [1:0] {IDLE, HELD, LONG_DONE} ipd_dec_state_type;

endpackage : ipd_pkg

// file: core/ipd_top.sv
// Purpose: Input press decoder with event routing and output signals
// Assumes: Single 100 MHz clock, synchronous active-low reset
// Notes:   Registers on a plain strobe port, read data one cycle later
`timescale 1ns/1ps

module ipd_top #(
  parameter int CYCLES_PER_MS = ipd_pkg::CYCLES_PER_MS
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdata,
  input  wire logic [1:0]  inputEventLine,
  input  wire logic [9:0]  battVolt,
  output logic [3:0]       outputPatternSignal,
  output logic             remoteOffAlertTrigger,
  output logic             remoteMildAlertTrigger,
  output logic             remoteHighAlertTrigger,
  output logic             batteryFortyEvent,
  output logic             batteryTwentyEvent,
  output logic             batteryCritical
);

  // ****************************************
  // Helpers
  // ****************************************
  // Select field: bit 4 enables, bits 3:0 pick an event
  function automatic logic eventHit(input logic [15:0] ev,
                                    input logic [4:0]  sel);
    eventHit = sel[4] & ev[sel[3:0]];
  endfunction : eventHit

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] ctrlReg;
  logic [31:0] thresholdReg;
  logic [31:0] battAReg;
  logic [31:0] battBReg;
  logic [31:0] alertReg;
  logic [3:0]  muteMaskReg;
  logic [27:0] portCfgReg [4];
  logic [15:0] pwmHalfReg;
  logic [31:0] rdataReg;

  wire wrCtrl   = regWr && regAddr == ipd_pkg::ADDR_CTRL;
  wire wrThresh = regWr && regAddr == ipd_pkg::ADDR_THRESH;
  wire wrBattA  = regWr && regAddr == ipd_pkg::ADDR_BATT_A;
  wire wrBattB  = regWr && regAddr == ipd_pkg::ADDR_BATT_B;
  wire wrAlert  = regWr && regAddr == ipd_pkg::ADDR_ALERT;
  wire wrMute   = regWr && regAddr == ipd_pkg::ADDR_MUTE;
  wire wrPwm    = regWr && regAddr == ipd_pkg::ADDR_PWM;

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      ctrlReg      <= ipd_pkg::CTRL_RST;
      thresholdReg <= ipd_pkg::THRESH_RST;
      battAReg     <= 32'h0000_0000;
      battBReg     <= 32'h0000_0000;
      alertReg     <= 32'h0000_0000;
      muteMaskReg  <= 4'h0;
      pwmHalfReg   <= 16'h0000;
    end
    else
    begin
      if (wrCtrl) ctrlReg <= regWdata & 32'h0000_000f;
      if (wrThresh) thresholdReg <= regWdata;
      if (wrBattA) battAReg <= regWdata & 32'h03ff_03ff;
      if (wrBattB) battBReg <= regWdata & 32'h03ff_03ff;
      if (wrAlert) alertReg <= regWdata & 32'h1f1f_1f1f;
      if (wrMute) muteMaskReg <= regWdata[3:0];
      if (wrPwm) pwmHalfReg <= regWdata[15:0];
    end
  end

  wire [15:0] shortMediumThreshold = thresholdReg[15:0];
  wire [15:0] mediumLongThreshold  = thresholdReg[31:16];
  wire [9:0]  batteryThreshold80   = battAReg[9:0];
  wire [9:0]  batteryThreshold60   = battAReg[25:16];
  wire [9:0]  batteryThreshold40   = battBReg[9:0];
  wire [9:0]  batteryThreshold20   = battBReg[25:16];
  wire        connected = ctrlReg[ipd_pkg::CTRL_CONN];
  wire        sleepOn   = ctrlReg[ipd_pkg::CTRL_SLEEP];

  // ****************************************
  // Millisecond tick
  // ****************************************
  logic [16:0] prescaleReg;
  logic        msTickReg;
  wire         prescaleEnd = prescaleReg == 17'(CYCLES_PER_MS - 1);

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      prescaleReg <= 17'h00000;
      msTickReg   <= 1'b0;
    end
    else
    begin
      prescaleReg <= prescaleEnd ? 17'h00000 : prescaleReg + 17'h00001;
      msTickReg   <= prescaleEnd;
    end
  end

  // ****************************************
  // Input lines
  // ****************************************
  ipd_pkg::ipd_press_type pressEv [2];
  logic [1:0]             lineActive;

  genvar li;
  generate
    for (li = 0; li < 2; li++)
    begin : gLine
      ipd_line_decoder uDec (
        .sys_clk    (sys_clk),
        .nrst       (nrst),
        .lineIn     (inputEventLine[li]),
        .activeHigh (ctrlReg[li]),
        .msTick     (msTickReg),
        .t1Ms       (shortMediumThreshold),
        .t2Ms       (mediumLongThreshold),
        .events     (pressEv[li]),
        .isActive   (lineActive[li])
      );
    end
  endgenerate

  // ****************************************
  // Battery levels
  // ****************************************
  logic [2:0] battLevelReg;
  logic       battFortyReg;
  logic       battTwentyReg;
  logic       battCriticalReg;

  wire [2:0] battLevel =
    (battVolt > batteryThreshold80) ? ipd_pkg::LEVEL_100 :
    (battVolt > batteryThreshold60) ? ipd_pkg::LEVEL_80  :
    (battVolt > batteryThreshold40) ? ipd_pkg::LEVEL_60  :
    (battVolt > batteryThreshold20) ? ipd_pkg::LEVEL_40  :
                                      ipd_pkg::LEVEL_20;

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      battLevelReg    <= ipd_pkg::LEVEL_100;
      battFortyReg    <= 1'b0;
      battTwentyReg   <= 1'b0;
      battCriticalReg <= 1'b0;
    end
    else
    begin
      battLevelReg    <= battLevel;
      battFortyReg    <= battLevel == ipd_pkg::LEVEL_40 &&
                         battLevelReg < ipd_pkg::LEVEL_40;
      battTwentyReg   <= battLevel == ipd_pkg::LEVEL_20 &&
                         battLevelReg != ipd_pkg::LEVEL_20;
      battCriticalReg <= battLevel == ipd_pkg::LEVEL_20;
    end
  end

  // ****************************************
  // Event routing
  // ****************************************
  wire [15:0] evVec = {2'b00, battTwentyReg, battFortyReg,
                       pressEv[1], pressEv[0]};
  wire offHit  = eventHit(evVec, alertReg[ipd_pkg::ALERT_OFF +: 5]);
  wire mildHit = eventHit(evVec, alertReg[ipd_pkg::ALERT_MILD +: 5]);
  wire highHit = eventHit(evVec, alertReg[ipd_pkg::ALERT_HIGH +: 5]);
  wire muteHit = eventHit(evVec, alertReg[ipd_pkg::ALERT_MUTE +: 5]);
  wire muteNow = muteHit && connected;

  logic remoteOffReg;
  logic remoteMildReg;
  logic remoteHighReg;

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      remoteOffReg  <= 1'b0;
      remoteMildReg <= 1'b0;
      remoteHighReg <= 1'b0;
    end
    else
    begin
      remoteOffReg  <= offHit;
      remoteMildReg <= mildHit;
      remoteHighReg <= highHit;
    end
  end

  // ****************************************
  // Output handlers and output stage
  // ****************************************
  logic       portActive [4];
  logic       phaseOn    [4];
  logic [7:0] phaseMs    [4];
  logic [3:0] pulsesLeft [4];
  logic       pinReg     [4];
  wire  [3:0] logicalOn;
  wire  [3:0] activeVec;
  wire  [3:0] invertVec;

  genvar pi;
  generate
    for (pi = 0; pi < 4; pi++)
    begin : gPort
      ipd_pkg::ipd_port_cfg_type cfg;
      assign cfg = portCfgReg[pi];
      wire start   = eventHit(evVec, {cfg.enable, cfg.evSel});
      wire stop    = sleepOn || (muteNow && muteMaskReg[pi]);
      wire step    = portActive[pi] && msTickReg && cfg.count != 4'h0;
      wire [7:0] msInc = phaseMs[pi] + 8'h01;
      wire onDone  = phaseOn[pi] && msInc >= cfg.onMs;
      wire offDone = !phaseOn[pi] && msInc >= cfg.offMs;

      always_ff @(posedge sys_clk)
      begin
        if (!nrst)
          portCfgReg[pi] <= 28'h0000000;
        else if (regWr && regAddr == ipd_pkg::ADDR_PORT0 + 4'(pi))
          portCfgReg[pi] <= regWdata[27:0];
      end

      // Count of zero is a steady level; sleep and mute beat a start
      always_ff @(posedge sys_clk)
      begin
        if (!nrst || stop)
        begin
          portActive[pi] <= 1'b0;
          phaseOn[pi]    <= 1'b0;
          phaseMs[pi]    <= 8'h00;
          pulsesLeft[pi] <= 4'h0;
        end
        else if (start)
        begin
          portActive[pi] <= 1'b1;
          phaseOn[pi]    <= 1'b1;
          phaseMs[pi]    <= 8'h00;
          pulsesLeft[pi] <= cfg.count;
        end
        else if (step && onDone)
        begin
          phaseOn[pi] <= 1'b0;
          phaseMs[pi] <= 8'h00;
        end
        else if (step && offDone)
        begin
          phaseMs[pi]    <= 8'h00;
          phaseOn[pi]    <= pulsesLeft[pi] > 4'h1 || cfg.repeatOn;
          portActive[pi] <= pulsesLeft[pi] > 4'h1 || cfg.repeatOn;
          pulsesLeft[pi] <= (pulsesLeft[pi] > 4'h1) ? pulsesLeft[pi] - 4'h1
                                                    : cfg.count;
        end
        else if (step)
          phaseMs[pi] <= msInc;
      end

      assign logicalOn[pi] = portActive[pi] && phaseOn[pi] && !sleepOn;
      assign activeVec[pi] = portActive[pi];
      assign invertVec[pi] = cfg.invert;
      assign outputPatternSignal[pi] = pinReg[pi];
    end
  endgenerate

  // Digital ports: polarity only
  genvar di;
  generate
    for (di = 0; di < 3; di++)
    begin : gDig
      always_ff @(posedge sys_clk)
      begin
        if (!nrst)
          pinReg[di] <= 1'b0;
        else
          pinReg[di] <= logicalOn[di] ^ invertVec[di];
      end
    end
  endgenerate

  // PWM port: 50% square while on, first half period high
  logic [15:0] pwmCntReg;
  logic        pwmLevelReg;
  wire         pwmEnd = pwmCntReg >= pwmHalfReg;

  always_ff @(posedge sys_clk)
  begin
    if (!nrst || !logicalOn[3])
    begin
      pwmCntReg   <= 16'h0000;
      pwmLevelReg <= 1'b1;
    end
    else
    begin
      pwmCntReg   <= pwmEnd ? 16'h0000 : pwmCntReg + 16'h0001;
      pwmLevelReg <= pwmEnd ? !pwmLevelReg : pwmLevelReg;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      pinReg[3] <= 1'b0;
    else
      pinReg[3] <= (logicalOn[3] && pwmLevelReg) ^ invertVec[3];
  end

  // ****************************************
  // Register read
  // ****************************************
  wire [31:0] statusWord = {18'h00000, battCriticalReg, battLevelReg,
                            activeVec, logicalOn, lineActive};
  wire [3:0]  portIdx = regAddr - ipd_pkg::ADDR_PORT0;
  wire        isPort  = regAddr >= ipd_pkg::ADDR_PORT0 &&
                        regAddr < ipd_pkg::ADDR_PWM;
  wire [31:0] readMux =
    (regAddr == ipd_pkg::ADDR_CTRL)   ? ctrlReg :
    (regAddr == ipd_pkg::ADDR_THRESH) ? thresholdReg :
    (regAddr == ipd_pkg::ADDR_BATT_A) ? battAReg :
    (regAddr == ipd_pkg::ADDR_BATT_B) ? battBReg :
    (regAddr == ipd_pkg::ADDR_ALERT)  ? alertReg :
    (regAddr == ipd_pkg::ADDR_MUTE)   ? {28'h0000000, muteMaskReg} :
    isPort ? {4'h0, portCfgReg[portIdx[1:0]]} :
    (regAddr == ipd_pkg::ADDR_PWM)    ? {16'h0000, pwmHalfReg} :
    (regAddr == ipd_pkg::ADDR_STATUS) ? statusWord : 32'h0000_0000;

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      rdataReg <= 32'h0000_0000;
    else
      rdataReg <= regRd ? readMux : 32'h0000_0000;
  end

  assign regRdata               = rdataReg;
  assign remoteOffAlertTrigger  = remoteOffReg;
  assign remoteMildAlertTrigger = remoteMildReg;
  assign remoteHighAlertTrigger = remoteHighReg;
  assign batteryFortyEvent      = battFortyReg;
  assign batteryTwentyEvent     = battTwentyReg;
  assign batteryCritical        = battCriticalReg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sleep_all_off_a: assert property (
    sleepOn && !regWr |=> outputPatternSignal == invertVec)
    else $error("port not off during sleep");
  mute_clears_a: assert property (
    muteNow |=> (activeVec & $past(muteMaskReg)) == 4'h0)
    else $error("muted port still active");
  remote_mild_a: assert property (
    remoteMildAlertTrigger |-> $past(evVec[alertReg[11:8]])
                               && alertReg[12])
    else $error("mild alert without its event");
  batt_forty_a: assert property (
    batteryFortyEvent |-> battLevelReg == ipd_pkg::LEVEL_40
                          && $past(battLevelReg) < ipd_pkg::LEVEL_40)
    else $error("forty percent event at wrong level");
  batt_crit_a: assert property (
    batteryCritical == (battLevelReg == ipd_pkg::LEVEL_20))
    else $error("critical flag disagrees with level");
  pwm_first_a: assert property (
    $rose(logicalOn[3]) |=> outputPatternSignal[3] == !invertVec[3])
    else $error("pwm first pulse not high");

  mute_seen_c: cover property (muteNow && (activeVec & muteMaskReg) != 4'h0);
  batt_twenty_c: cover property (batteryTwentyEvent);
  pwm_run_c: cover property (logicalOn[3] && pwmEnd);

endmodule : ipd_top
